// file: hw/pit_top.sv
module pit_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // core status
    input wire logic core_in_debug,
    // axi4-lite write address, data and response
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupts
    output logic tick_irq,
    output logic sys_irq
);
    // ******************************
    // state
    // ******************************
    pit_pkg::pit_mode_t mode_q;
    logic [19:0] count_q;
    logic [11:0] tally_q;
    logic flag_q;
    logic run_q;
    logic [3:0] pre_q;
    logic [1:0] istat_q;
    logic [1:0] ien_q;
    logic [7:0] aw_addr_q;
    logic aw_got_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_got_q;

    logic tick;
    logic hit;
    logic wr_fire;
    logic rd_fire;
    logic clr_read;
    logic [31:0] rd_word;
    logic wr_ok;
    logic rd_ok;

    // tick pulses one clock in sixteen; debug freezes the divider too
    assign tick = (pre_q == 4'(pit_pkg::PIT_PRESCALE - 5'h01)) && !core_in_debug;
    assign hit = tick && run_q && (count_q == mode_q.limit);

    // ******************************
    // prescaler
    // ******************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_q <= 4'h0;
        end else if (clk_en && !core_in_debug) begin
            pre_q <= pre_q + 4'h1;
        end
    end

    // ******************************
    // primary counter and run latch
    // ******************************
    // enable is looked at only while the count sits at zero, so a disable
    // made while the count is above zero finishes the interval in progress
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
        end else if (clk_en && count_q == 20'h00000) begin
            run_q <= mode_q.timer_on;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 20'h00000;
        end else if (clk_en && tick && run_q) begin
            if (count_q == mode_q.limit) begin
                count_q <= 20'h00000;
            end else begin
                count_q <= count_q + 20'h00001;
            end
        end
    end

    // ******************************
    // tally and reached flag
    // ******************************
    // a completing interval in the same cycle as a clearing read wins:
    // the tally restarts at one and the flag stays set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tally_q <= 12'h000;
        end else if (clk_en) begin
            if (hit && clr_read) begin
                tally_q <= 12'h001;
            end else if (hit) begin
                tally_q <= tally_q + 12'h001;
            end else if (clr_read) begin
                tally_q <= 12'h000;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= 1'b0;
        end else if (clk_en) begin
            if (hit) begin
                flag_q <= 1'b1;
            end else if (clr_read) begin
                flag_q <= 1'b0;
            end
        end
    end

    // ******************************
    // axi write path
    // ******************************
    assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
    assign wr_ok = (aw_addr_q[7:4] == 4'h0) || (aw_addr_q == pit_pkg::PIT_OFF_ISTAT)
        || (aw_addr_q == pit_pkg::PIT_OFF_IEN);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (clk_en) begin
            s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (clk_en) begin
            s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_got_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pit_pkg::PIT_RESP_OK;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? pit_pkg::PIT_RESP_OK : pit_pkg::PIT_RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // mode write never touches the counters; the limit is just compared later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= pit_pkg::pit_mode_t'({pit_pkg::PIT_MODE_RST[25:24],
                pit_pkg::PIT_LIMIT_RST});
        end else if (clk_en && wr_fire && aw_addr_q == {4'h0, pit_pkg::PIT_OFF_MODE}) begin
            if (w_strb_q[0]) mode_q.limit[7:0] <= w_data_q[7:0];
            if (w_strb_q[1]) mode_q.limit[15:8] <= w_data_q[15:8];
            if (w_strb_q[2]) mode_q.limit[19:16] <= w_data_q[19:16];
            if (w_strb_q[3]) begin
                mode_q.timer_on <= w_data_q[pit_pkg::PIT_BIT_TIMER_ON];
                mode_q.irq_on <= w_data_q[pit_pkg::PIT_BIT_IRQ_ON];
            end
        end
    end

    // ******************************
    // system interrupt status and mask
    // ******************************
    // bit 0: interval completed, bit 1: clearing read; set beats write-one-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_q <= 2'h0;
        end else if (clk_en) begin
            if (wr_fire && aw_addr_q == pit_pkg::PIT_OFF_ISTAT && w_strb_q[0]) begin
                istat_q <= (istat_q & ~w_data_q[1:0]) | {clr_read, hit};
            end else begin
                istat_q <= istat_q | {clr_read, hit};
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ien_q <= 2'h0;
        end else if (clk_en && wr_fire && aw_addr_q == pit_pkg::PIT_OFF_IEN && w_strb_q[0]) begin
            ien_q <= w_data_q[1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_irq <= 1'b0;
            sys_irq <= 1'b0;
        end else if (clk_en) begin
            // a hit beside a clearing read keeps the flag, so the line must stay up too
            tick_irq <= (hit || (flag_q && !clr_read)) && mode_q.irq_on;
            sys_irq <= |((istat_q | {clr_read, hit}) & ien_q);
        end
    end

    // ******************************
    // axi read path
    // ******************************
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign clr_read = clk_en && rd_fire && s_axi_araddr == {4'h0, pit_pkg::PIT_OFF_CLEAR};
    assign rd_ok = s_axi_araddr[7:4] == 4'h0 || s_axi_araddr == pit_pkg::PIT_OFF_ISTAT
        || s_axi_araddr == pit_pkg::PIT_OFF_IEN;

    always_comb begin
        rd_word = 32'h00000000;
        case (s_axi_araddr)
            {4'h0, pit_pkg::PIT_OFF_MODE}: begin
                rd_word[19:0] = mode_q.limit;
                rd_word[pit_pkg::PIT_BIT_TIMER_ON] = mode_q.timer_on;
                rd_word[pit_pkg::PIT_BIT_IRQ_ON] = mode_q.irq_on;
            end
            {4'h0, pit_pkg::PIT_OFF_FLAG}: rd_word[pit_pkg::PIT_BIT_FLAG] = flag_q;
            {4'h0, pit_pkg::PIT_OFF_CLEAR}, {4'h0, pit_pkg::PIT_OFF_SNAP}: begin
                rd_word = {tally_q, count_q};
            end
            pit_pkg::PIT_OFF_ISTAT: rd_word[1:0] = istat_q;
            pit_pkg::PIT_OFF_IEN: rd_word[1:0] = ien_q;
            default: rd_word = 32'h00000000;
        endcase
    end

    // one read at a time; arready rises only while no answer is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= pit_pkg::PIT_RESP_OK;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? pit_pkg::PIT_RESP_OK : pit_pkg::PIT_RESP_ERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // pit_top

// file: hw/pit_pkg.sv
package pit_pkg;
    // ******************************
    // register map
    // ******************************
    localparam logic [3:0] PIT_OFF_MODE = 4'h0;
    localparam logic [3:0] PIT_OFF_FLAG = 4'h4;
    localparam logic [3:0] PIT_OFF_CLEAR = 4'h8;
    localparam logic [3:0] PIT_OFF_SNAP = 4'hC;
    localparam logic [3:0] PIT_OFF_IMASK = 4'h0 + 4'h0; // unused slot kept below
    localparam logic [7:0] PIT_OFF_ISTAT = 8'h10;
    localparam logic [7:0] PIT_OFF_IEN = 8'h14;

    // ******************************
    // field layout and reset values
    // ******************************
    localparam int PIT_CNT_W = 20;
    localparam int PIT_TALLY_W = 12;
    localparam int PIT_BIT_TIMER_ON = 24;
    localparam int PIT_BIT_IRQ_ON = 25;
    localparam int PIT_TALLY_LSB = 20;
    localparam int PIT_BIT_FLAG = 0;
    localparam logic [19:0] PIT_LIMIT_RST = 20'hFFFFF;
    localparam logic [31:0] PIT_MODE_RST = 32'h000FFFFF;
    localparam logic [4:0] PIT_PRESCALE = 5'h10;

    // ******************************
    // axi responses
    // ******************************
    localparam logic [1:0] PIT_RESP_OK = 2'h0;
    localparam logic [1:0] PIT_RESP_ERR = 2'h2;

    typedef struct packed {
        logic irq_on;
        logic timer_on;
        logic [19:0] limit;
    } pit_mode_t;
endpackage

// file: verification/pit_top_sva.sv
module pit_top_sva (
    // clock, reset and run
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt
    input wire logic tick_irq
);
    logic ar_hit;
    logic [7:0] ra_q;
    assign ar_hit = clk_en && s_axi_arvalid && s_axi_arready;
    // remember the read address so the returned word can be judged by register
    always_ff @(posedge aclk) begin
        if (!aresetn) ra_q <= 8'h00;
        else if (ar_hit) ra_q <= s_axi_araddr;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ******************************
    // properties
    // ******************************
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_awready_pulse: assert property (clk_en && s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    a_read_ok: assert property (ar_hit && s_axi_araddr < 8'h18 && s_axi_araddr[1:0] == 2'h0
        |=> s_axi_rvalid && s_axi_rresp == pit_pkg::PIT_RESP_OK) else $error("read not ok");
    a_read_err: assert property (ar_hit && s_axi_araddr >= 8'h18
        |=> s_axi_rvalid && s_axi_rresp == pit_pkg::PIT_RESP_ERR) else $error("no error");
    a_status_clean: assert property (
        s_axi_rvalid && ra_q == 8'h04 |-> s_axi_rdata[31:1] == 31'h0) else $error("status bits");
    a_mode_resv: assert property (
        s_axi_rvalid && ra_q == 8'h00 |-> s_axi_rdata[31:26] == 6'h0 && s_axi_rdata[23:20] == 4'h0)
        else $error("mode reserved bits");
    a_snap_keeps: assert property (
        ar_hit && s_axi_araddr == 8'h0C && tick_irq && !s_axi_awvalid && !s_axi_wvalid
        && !s_axi_bvalid |=> tick_irq [*3]) else $error("snapshot dropped irq");
    // main scenarios seen
    c_irq: cover property ($rose(tick_irq));
    c_clear: cover property (ar_hit && s_axi_araddr == 8'h08);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == pit_pkg::PIT_RESP_ERR);
endmodule // pit_top_sva

bind pit_top pit_top_sva pit_top_sva_i (.*);

// file: verification/tb.sv
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin bad_count++; \
    $display("ERROR %s exp %0h got %0h", n, (e), (s)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, core_in_debug = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, tick_irq, sys_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    pit_top pit_top_i (.*);
    always #50 aclk = ~aclk;
    // hang guard: the whole run needs well under this many cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            wrap_up();
        end
    end
    // ******************************
    // bus tasks
    // ******************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        `CHK("bresp", (a >= 8'h18) ? pit_pkg::PIT_RESP_ERR : pit_pkg::PIT_RESP_OK, s_axi_bresp)
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        `CHK("rresp", (a >= 8'h18) ? pit_pkg::PIT_RESP_ERR : pit_pkg::PIT_RESP_OK, s_axi_rresp)
        s_axi_rready <= 1'b0;
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (tick_irq !== 1'b1 && n < 300);
    endtask
    // ******************************
    // scenarios
    // ******************************
    task automatic t_reset();
        logic [31:0] d;
        for (int i = 0; i < 4; i++) begin
            rd(8'(i * 4), d);
            `CHK("reset", (i == 0) ? 32'h000F_FFFF : 32'h0000_0000, d)
        end
    endtask
    task automatic t_period();
        int t0;
        logic [31:0] d;
        wr(8'h00, 32'h0300_0003); // limit 3, so one interval is 4 ticks of 16 clocks
        wait_irq();
        t0 = cyc;
        rd(8'h0C, d);
        `CHK("snapshot", 32'h0010_0000, d)
        `CHK("irq kept", 1'b1, tick_irq)
        rd(8'h08, d);
        `CHK("clearing", 32'h0010_0000, d)
        repeat (2) @(posedge aclk);
        `CHK("irq ack", 1'b0, tick_irq)
        wait_irq();
        `CHK("period", 64, cyc - t0)
    endtask
    task automatic t_irq();
        logic [31:0] d, e;
        wr(8'h00, 32'h0100_0003);
        repeat (80) @(posedge aclk);
        `CHK("irq masked", 1'b0, tick_irq)
        rd(8'h04, d);
        `CHK("flag", 32'h0000_0001, d)
        wr(8'h14, 32'h1);
        repeat (2) @(posedge aclk);
        `CHK("sys on", 1'b1, sys_irq)
        wr(8'h14, 32'h0);
        repeat (2) @(posedge aclk);
        `CHK("sys masked", 1'b0, sys_irq)
        wr(8'h00, 32'h0000_0003); // off: the running interval finishes, then rests at zero
        repeat (80) @(posedge aclk);
        rd(8'h0C, d);
        `CHK("rest", 20'h0, d[19:0])
        repeat (40) @(posedge aclk);
        rd(8'h0C, e);
        `CHK("rest held", d, e)
        wr(8'h10, 32'h3);
        rd(8'h10, d);
        `CHK("status cleared", 32'h0, d)
        wr(8'h14, 32'h1);
        repeat (2) @(posedge aclk);
        `CHK("sys idle", 1'b0, sys_irq)
    endtask
    task automatic t_debug();
        logic [31:0] a, b, c;
        wr(8'h00, 32'h010F_FFFF);
        repeat (100) @(posedge aclk);
        core_in_debug <= 1'b1;
        rd(8'h0C, a);
        repeat (40) @(posedge aclk);
        rd(8'h0C, b);
        `CHK("frozen", a, b)
        core_in_debug <= 1'b0;
        wr(8'h00, 32'h0100_8000);
        repeat (40) @(posedge aclk);
        rd(8'h0C, c);
        `CHK("no restart", 1'b1, c[19:0] > a[19:0])
        rd(8'h00, c);
        `CHK("mode back", 32'h0100_8000, c)
        // clock enable low freezes everything: ten ticks would pass otherwise
        rd(8'h0C, a);
        clk_en <= 1'b0;
        repeat (160) @(posedge aclk);
        clk_en <= 1'b1;
        rd(8'h0C, b);
        `CHK("clk_en frozen", 1'b1, (b[19:0] - a[19:0]) <= 20'h00001)
        rd(8'h18, c);
        wr(8'h1C, 32'h0);
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_period();
        t_irq();
        t_debug();
        wrap_up();
    end
endmodule // tb
